//--- rtl/ocb_overcurrent_count.sv
// Overcurrent count, leading-edge blanking and APB registers
`timescale 1ns/1ns
//
// Summary of operation
// - Count consecutive limited cycles, 7-bit, versus limit
// - Raise fault when count reaches limit
// - Fault flag when limit field equals count
// - Count readable anytime without disturbing it
// - Normal cycle end clears counter
// - Normal cycle interrupting run clears at end
// - Limit 15 faults on sixteenth event only
// - At limit reset count, start bypass if enabled
// - Bypass enable zero blocks automatic shutdown
// - Comparator control bit 7 enables comparator
// - Bit 6 shows limit cycle in progress
// - Bits 5-2 threshold code, 50 to 800 mV
// - Blanking code bits 7-6: 0/4/8/16 cycles
// - Status bits 6-0 count, bit 7 zero
// - Fault bit 7 reads fault active
// - Limit field writable, resets to all ones
// - Over threshold truncates phase, flags event
// - Selected phase rising edge starts blanking
// - Comparator ignored while blanking
module ocb_overcurrent_count
  import ocb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Analog comparator and PWM generator
  input  wire logic        peakSenseInput,
  input  wire ocb_pwm_t    pwmIn,
  output ocb_analog_t      analogCfg,
  output logic             phaseTruncate,
  output logic             bypassStart,
  output logic             overcurrentFaultFlag
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic peakMeta_r, peakSync_r;
  logic [OCB_PHASES:0] pwmMeta_r, pwmSync_r;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      peakMeta_r <= 1'b0;
      peakSync_r <= 1'b0;
      pwmMeta_r  <= '0;
      pwmSync_r  <= '0;
    end
    else
    begin
      peakMeta_r <= peakSenseInput;
      peakSync_r <= peakMeta_r;
      pwmMeta_r  <= pwmIn;
      pwmSync_r  <= pwmMeta_r;
    end
  end

  wire ocb_pwm_t pwmS = pwmSync_r;
  logic [OCB_PHASES-1:0] phasePrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] compCtrl_r;
  logic [7:0] blankCtrl_r;
  logic [6:0] faultLimit_r;
  logic       hwBypassEnable_r;
  logic [6:0] limitCount_r;
  logic [6:0] limitCount_nxt;
  logic       eventPending_r;
  logic       fault_r;
  logic [4:0] blankCnt_r;
  logic [4:0] blankCnt_nxt;

  wire        accessPhase = psel & penable;
  wire        wrEn        = accessPhase & pwrite;
  wire        selComp     = paddr[11:2] == {2'b00, OCB_IDX_COMP};
  wire        selCntSt    = paddr[11:2] == {2'b00, OCB_IDX_CNTST};
  wire        selBlank    = paddr[11:2] == {2'b00, OCB_IDX_BLANK};
  wire        selFault    = paddr[11:2] == {2'b00, OCB_IDX_FAULT};
  wire        selPwmc     = paddr[11:2] == {2'b00, OCB_IDX_PWMC};
  wire        selAny      = selComp | selCntSt | selBlank | selFault | selPwmc;

  ////////////////////////////////////////////////////////////////////////////
  // Blanking and comparator qualification
  wire [OCB_PHASES-1:0] phaseSel  = blankCtrl_r[OCB_PHASES-1:0];
  wire                  blankTrig = |(phaseSel & pwmS.phaseOutput & ~phasePrev_r);
  wire [1:0]            blkCode   = blankCtrl_r[OCB_BLK_CODE_LSB +: 2];
  wire [4:0]            blkLen    = (blkCode == 2'b00) ? OCB_BLK_LEN0 :
                                    (blkCode == 2'b01) ? OCB_BLK_LEN1 :
                                    (blkCode == 2'b10) ? OCB_BLK_LEN2 : OCB_BLK_LEN3;
  wire                  blanking  = blankTrig ? (blkLen != 5'h00) : (blankCnt_r != 5'h00);
  wire                  compEn    = compCtrl_r[OCB_COMP_EN_BIT];
  wire                  limitHit  = compEn & peakSync_r & ~blanking;
  wire                  cycLimited = eventPending_r | limitHit;
  wire [6:0]            countInc  = limitCount_r + 7'h01;
  wire                  reachLim  = pwmS.cycleEnd & cycLimited &
                                    (limitCount_r == faultLimit_r);

  always_comb
  begin
    blankCnt_nxt = blankCnt_r;
    if (blankTrig)
      blankCnt_nxt = (blkLen == 5'h00) ? 5'h00 : 5'(blkLen - 5'h01);
    else if (blankCnt_r != 5'h00)
      blankCnt_nxt = 5'(blankCnt_r - 5'h01);
  end

  // Counter: limit of N faults on the (N+1)th limited cycle
  always_comb
  begin
    limitCount_nxt = limitCount_r;
    if (pwmS.cycleEnd)
    begin
      if (!cycLimited)
        limitCount_nxt = OCB_RST_COUNT;
      else if (reachLim)
        limitCount_nxt = OCB_RST_COUNT;
      else
        limitCount_nxt = countInc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Edge detector and blanking timer
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phasePrev_r <= '0;
      blankCnt_r  <= 5'h00;
    end
    else
    begin
      phasePrev_r <= pwmS.phaseOutput;
      blankCnt_r  <= blankCnt_nxt;
    end
  end

  // Limit event remembered until the cycle ends
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      eventPending_r <= 1'b0;
    else
      eventPending_r <= pwmS.cycleEnd ? 1'b0 : cycLimited;
  end

  // Consecutive counter
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      limitCount_r <= OCB_RST_COUNT;
    else
      limitCount_r <= limitCount_nxt;
  end

  // Fault stays until the next cycle end; set wins over clear
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_r <= 1'b0;
    else if (reachLim)
      fault_r <= 1'b1;
    else if (pwmS.cycleEnd)
      fault_r <= 1'b0;
  end

  // Software registers; bit 6 of comparator control is status only
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      compCtrl_r <= OCB_RST_COMP;
    else if (wrEn && selComp)
      compCtrl_r <= {pwdata[7], 1'b0, pwdata[5:0]};
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      blankCtrl_r <= OCB_RST_BLANK;
    else if (wrEn && selBlank)
      blankCtrl_r <= pwdata[7:0];
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      faultLimit_r <= OCB_RST_LIMIT;
    else if (wrEn && selFault)
      faultLimit_r <= pwdata[6:0];
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      hwBypassEnable_r <= OCB_RST_BYP;
    else if (wrEn && selPwmc)
      hwBypassEnable_r <= pwdata[OCB_PWMC_BYP_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reads have no side effects on counting
  wire [7:0] compRd  = {compCtrl_r[7], cycLimited, compCtrl_r[5:0]};
  wire [7:0] cntRd   = {1'b0, limitCount_r};
  wire [7:0] faultRd = {fault_r, faultLimit_r};
  wire [7:0] rdByte  = selComp  ? compRd :
                       selCntSt ? cntRd :
                       selBlank ? blankCtrl_r :
                       selFault ? faultRd :
                       selPwmc  ? {7'h00, hwBypassEnable_r} : 8'h00;

  // Zero-wait-state slave: ready in the first access-phase cycle
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      prdata  <= {24'h000000, rdByte};
      pslverr <= psel & ~penable & ~selAny;
    end
  end

  // Analog settings from flops, so the pins never glitch on a write
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      analogCfg <= '0;
    else
      analogCfg <= {compEn, compCtrl_r[OCB_THR_LSB +: 4],
                    compCtrl_r[OCB_HYS_LSB +: 2]};
  end

  // Event outputs
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phaseTruncate        <= 1'b0;
      bypassStart          <= 1'b0;
      overcurrentFaultFlag <= 1'b0;
    end
    else
    begin
      phaseTruncate        <= limitHit;
      bypassStart          <= reachLim & hwBypassEnable_r;
      overcurrentFaultFlag <= reachLim | (fault_r & ~pwmS.cycleEnd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_COUNT_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
    pwmS.cycleEnd && !cycLimited |=> limitCount_r == 7'h00)
    else $error("count not cleared on normal cycle");
  AST_COUNT_INC: assert property (@(posedge core_clk) disable iff (sys_rst)
    pwmS.cycleEnd && cycLimited && !reachLim |=> limitCount_r == $past(limitCount_r) + 7'h01)
    else $error("count did not advance");
  AST_LIMIT_RESET: assert property (@(posedge core_clk) disable iff (sys_rst)
    reachLim |=> limitCount_r == 7'h00 && fault_r)
    else $error("limit did not reset count");
  AST_BYPASS: assert property (@(posedge core_clk) disable iff (sys_rst)
    bypassStart |-> $past(hwBypassEnable_r) && $past(reachLim))
    else $error("bypass without enable");
  AST_BLANK: assert property (@(posedge core_clk) disable iff (sys_rst)
    blanking |-> !limitHit)
    else $error("event during blanking");
  AST_COMP_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !compEn |=> !phaseTruncate)
    else $error("event with comparator off");
  AST_FAULT_RD: assert property (@(posedge core_clk) disable iff (sys_rst)
    overcurrentFaultFlag |-> $past(reachLim) || $past(fault_r))
    else $error("fault flag without cause");
  AST_STATUS_B7: assert property (@(posedge core_clk) disable iff (sys_rst)
    pready && $past(selCntSt) |-> prdata[7] == 1'b0)
    else $error("status bit 7 nonzero");

  AST_FAULT_AT_LIMIT: assert property (@(posedge core_clk) disable iff (sys_rst)
    reachLim |-> limitCount_r == faultLimit_r)
    else $error("fault below limit");

  AST_FAULT_FLAG: assert property (@(posedge core_clk) disable iff (sys_rst)
    reachLim |=> overcurrentFaultFlag)
    else $error("fault flag missing at limit");

  AST_FAULT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    fault_r && !pwmS.cycleEnd |=> fault_r)
    else $error("fault dropped inside cycle");

  AST_NORMAL_NO_FAULT: assert property (@(posedge core_clk) disable iff (sys_rst)
    pwmS.cycleEnd && !cycLimited |=> !fault_r)
    else $error("fault kept after normal cycle");

  AST_COUNT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
    !pwmS.cycleEnd |=> $stable(limitCount_r))
    else $error("count moved inside cycle");

  AST_BYPASS_EN: assert property (@(posedge core_clk) disable iff (sys_rst)
    reachLim && hwBypassEnable_r |=> bypassStart)
    else $error("bypass not started");

  AST_NO_BYPASS: assert property (@(posedge core_clk) disable iff (sys_rst)
    !hwBypassEnable_r |=> !bypassStart)
    else $error("bypass while disabled");

  AST_COMP_STATUS: assert property (@(posedge core_clk) disable iff (sys_rst)
    pready && $past(selComp) |-> prdata[6] == $past(cycLimited))
    else $error("limit status bit wrong");

  AST_CFG_MIRROR: assert property (@(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> analogCfg.thresholdCode == $past(compCtrl_r[5:2]) &&
             analogCfg.hysteresisCode == $past(compCtrl_r[1:0]))
    else $error("analog settings wrong");

  AST_BLANK_LOAD16: assert property (@(posedge core_clk) disable iff (sys_rst)
    blankTrig && blkCode == 2'b11 |=> blankCnt_r == 5'h0F)
    else $error("blank 16 length wrong");

  AST_BLANK_LOAD8: assert property (@(posedge core_clk) disable iff (sys_rst)
    blankTrig && blkCode == 2'b10 |=> blankCnt_r == 5'h07)
    else $error("blank 8 length wrong");

  AST_BLANK_LOAD4: assert property (@(posedge core_clk) disable iff (sys_rst)
    blankTrig && blkCode == 2'b01 |=> blankCnt_r == 5'h03)
    else $error("blank 4 length wrong");

  AST_BLANK_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
    blankTrig && blkCode == 2'b00 && blankCnt_r == 5'h00 |-> !blanking)
    else $error("blank with zero code");

  AST_LIMIT_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrEn && selFault |=> faultLimit_r == $past(pwdata[6:0]))
    else $error("limit write lost");

  AST_RD_COUNT: assert property (@(posedge core_clk) disable iff (sys_rst)
    pready && $past(selCntSt) |-> prdata[6:0] == $past(limitCount_r))
    else $error("count read wrong");

  AST_EVT_TRUNC: assert property (@(posedge core_clk) disable iff (sys_rst)
    limitHit |=> phaseTruncate)
    else $error("event did not truncate");

  AST_NO_EVENT_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !compEn |-> !limitHit)
    else $error("event while disabled");

  AST_FAULT_BIT_RD: assert property (@(posedge core_clk) disable iff (sys_rst)
    pready && $past(selFault) |-> prdata[7] == $past(fault_r))
    else $error("fault bit read wrong");

  COV_FAULT: cover property (@(posedge core_clk) reachLim);
  COV_BYPASS: cover property (@(posedge core_clk) bypassStart);
  COV_BREAK: cover property (@(posedge core_clk)
    pwmS.cycleEnd && !cycLimited && limitCount_r != 7'h00);
  COV_BLANKED_PEAK: cover property (@(posedge core_clk)
    blanking && peakSync_r && compEn);
  COV_NO_BYPASS: cover property (@(posedge core_clk)
    reachLim && !hwBypassEnable_r);

endmodule : ocb_overcurrent_count

//--- rtl/ocb_pkg.sv
// Package: register map, field layout and carriers for the overcurrent count block
package ocb_pkg;

  // Register byte offsets (printed offsets are not all word aligned: kept as indices)
  localparam logic [7:0] OCB_IDX_COMP  = 8'hA0;
  localparam logic [7:0] OCB_IDX_CNTST = 8'hD2;
  localparam logic [7:0] OCB_IDX_BLANK = 8'hD6;
  localparam logic [7:0] OCB_IDX_FAULT = 8'hD7;
  localparam logic [7:0] OCB_IDX_PWMC  = 8'hE0;
  localparam logic [9:0] OCB_ADDR_COMP  = {OCB_IDX_COMP, 2'b00};
  localparam logic [9:0] OCB_ADDR_CNTST = {OCB_IDX_CNTST, 2'b00};
  localparam logic [9:0] OCB_ADDR_BLANK = {OCB_IDX_BLANK, 2'b00};
  localparam logic [9:0] OCB_ADDR_FAULT = {OCB_IDX_FAULT, 2'b00};
  localparam logic [9:0] OCB_ADDR_PWMC  = {OCB_IDX_PWMC, 2'b00};

  // Field positions
  localparam int OCB_COMP_EN_BIT   = 7;
  localparam int OCB_COMP_EVT_BIT  = 6;
  localparam int OCB_THR_LSB       = 2;
  localparam int OCB_HYS_LSB       = 0;
  localparam int OCB_BLK_CODE_LSB  = 6;
  localparam int OCB_FLT_FLAG_BIT  = 7;
  localparam int OCB_PWMC_BYP_BIT  = 0;

  // Reset values
  localparam logic [7:0] OCB_RST_COMP  = 8'h00;
  localparam logic [7:0] OCB_RST_BLANK = 8'h00;
  localparam logic [6:0] OCB_RST_LIMIT = 7'h7F;
  localparam logic [6:0] OCB_RST_COUNT = 7'h00;
  localparam logic       OCB_RST_BYP   = 1'b0;

  // Blanking lengths in PWM clock cycles per code
  localparam logic [4:0] OCB_BLK_LEN0 = 5'h00;
  localparam logic [4:0] OCB_BLK_LEN1 = 5'h04;
  localparam logic [4:0] OCB_BLK_LEN2 = 5'h08;
  localparam logic [4:0] OCB_BLK_LEN3 = 5'h10;

  localparam int OCB_PHASES = 6;

  // Analog settings carried to comparator and DAC
  typedef struct packed {
    logic       enable;
    logic [3:0] thresholdCode;
    logic [1:0] hysteresisCode;
  } ocb_analog_t;

  // Timing inputs from the PWM generator
  typedef struct packed {
    logic                  cycleEnd;
    logic [OCB_PHASES-1:0] phaseOutput;
  } ocb_pwm_t;

endpackage : ocb_pkg

//--- bench/ocb_pwm_model.sv
// Comparator and PWM generator model for the overcurrent count block
`timescale 1ns/1ns
module ocb_pwm_model
  import ocb_pkg::*;
(
  // Clock
  input  wire logic        core_clk,
  // Block side
  input  wire ocb_analog_t analogCfg,
  output logic             peakSenseInput,
  output ocb_pwm_t         pwmIn
);
  initial
  begin
    peakSenseInput = 1'b0;
    pwmIn          = '0;
  end

  // One switching cycle on phase 1; peakAt 0 means no trip
  task automatic run_cycle(input int peakAt);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge core_clk);
      pwmIn.phaseOutput <= (i < 20) ? 6'h01 : 6'h00;
      // Disabled comparator never trips
      peakSenseInput <= analogCfg.enable && peakAt != 0 && i >= peakAt && i < peakAt + 3;
      pwmIn.cycleEnd <= (i == 22);
    end
    // Tail covers the two-flop sync of cycleEnd
    repeat (6) @(posedge core_clk);
  endtask : run_cycle
endmodule : ocb_pwm_model

//--- bench/test_overcurrent_count_and_blanking.sv
// Register and count tests for the overcurrent count block
`timescale 1ns/1ns
module test_overcurrent_count_and_blanking
  import ocb_pkg::*;
;
  logic        core_clk, sys_rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, peakSenseInput, phaseTruncate, bypassStart;
  logic        overcurrentFaultFlag, qErr;
  ocb_pwm_t    pwmIn;
  ocb_analog_t analogCfg;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          bypassCount = 0;
  int          truncCount = 0;

  ocb_overcurrent_count uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .peakSenseInput(peakSenseInput), .pwmIn(pwmIn),
    .analogCfg(analogCfg), .phaseTruncate(phaseTruncate), .bypassStart(bypassStart),
    .overcurrentFaultFlag(overcurrentFaultFlag));
  ocb_pwm_model mdl (.core_clk(core_clk), .analogCfg(analogCfg),
    .peakSenseInput(peakSenseInput), .pwmIn(pwmIn));

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (bypassStart === 1'b1) bypassCount++;
  always @(posedge core_clk) if (phaseTruncate === 1'b1) truncCount++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'b00, a}; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 50)
    begin
      num_errors++;
      summarize();
    end
    q = prdata;
    qErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    summarize();
  end

  initial
  begin
    core_clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OCB_ADDR_COMP, 32'h00);
    rd(OCB_ADDR_BLANK, 32'h00);
    rd(OCB_ADDR_CNTST, 32'h00);
    rd(OCB_ADDR_FAULT, 32'h7F);
    rd(10'h001, 32'h00);
    check({31'h0, qErr}, 32'h1);
    // Bit 6 is status only
    apb(1'b1, OCB_ADDR_COMP, 32'hFD);
    rd(OCB_ADDR_COMP, 32'hBD);
    check({25'h0, analogCfg}, 32'h7D);
    apb(1'b1, OCB_ADDR_BLANK, 32'hC1);
    rd(OCB_ADDR_BLANK, 32'hC1);
    apb(1'b1, OCB_ADDR_FAULT, 32'h83);
    rd(OCB_ADDR_FAULT, 32'h03);
    apb(1'b1, OCB_ADDR_PWMC, 32'h01);
    // Trip inside the 16-cycle blank is ignored
    mdl.run_cycle(2);
    rd(OCB_ADDR_CNTST, 32'h00);
    check(truncCount, 0);
    repeat (3) mdl.run_cycle(18);
    rd(OCB_ADDR_CNTST, 32'h03);
    check(truncCount, 9);
    mdl.run_cycle(0);
    rd(OCB_ADDR_CNTST, 32'h00);
    repeat (3) mdl.run_cycle(18);
    check({31'h0, overcurrentFaultFlag}, 32'h0);
    mdl.run_cycle(18);
    check({31'h0, overcurrentFaultFlag}, 32'h1);
    rd(OCB_ADDR_FAULT, 32'h83);
    rd(OCB_ADDR_CNTST, 32'h00);
    check(bypassCount, 1);
    // Same fault with the automatic shutdown disabled
    apb(1'b1, OCB_ADDR_PWMC, 32'h00);
    repeat (4) mdl.run_cycle(18);
    check({31'h0, overcurrentFaultFlag}, 32'h1);
    check(bypassCount, 1);
    mdl.run_cycle(0);
    rd(OCB_ADDR_FAULT, 32'h03);
    // Reset in mid-run restores the defaults
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OCB_ADDR_FAULT, 32'h7F);
    check({25'h0, analogCfg}, 32'h00);
    summarize();
  end
endmodule : test_overcurrent_count_and_blanking
